// [common/asp_pkg.sv]
// Shared constants of the asynchronous serial port.
package asp_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [15:0] ASP_IDX_RX_CTL = 16'hfed0;
    localparam logic [15:0] ASP_IDX_TX_CTL = 16'hfed1;
    localparam logic [15:0] ASP_IDX_BAUD = 16'hfed2;
    localparam logic [15:0] ASP_IDX_TX_DATA = 16'hfed3;
    localparam logic [15:0] ASP_IDX_RX_DATA = 16'hfed4;

    // Byte addresses on the register bus.
    localparam logic [31:0] ASP_ADDR_RX_CTL = {14'h0000, ASP_IDX_RX_CTL, 2'b00};
    localparam logic [31:0] ASP_ADDR_TX_CTL = {14'h0000, ASP_IDX_TX_CTL, 2'b00};
    localparam logic [31:0] ASP_ADDR_BAUD = {14'h0000, ASP_IDX_BAUD, 2'b00};
    localparam logic [31:0] ASP_ADDR_TX_DATA = {14'h0000, ASP_IDX_TX_DATA, 2'b00};
    localparam logic [31:0] ASP_ADDR_RX_DATA = {14'h0000, ASP_IDX_RX_DATA, 2'b00};

    // Receive control register field positions.
    localparam int ASP_RXC_PRESCALE = 7;
    localparam int ASP_RXC_START_DET = 6;
    localparam int ASP_RXC_RX_RUN = 5;
    localparam int ASP_RXC_STOP_ERR = 4;
    localparam int ASP_RXC_SPARE = 3;
    localparam int ASP_RXC_NINTH = 2;
    localparam int ASP_RXC_DONE = 1;
    localparam int ASP_RXC_IRQ_EN = 0;

    // Transmit control register field positions.
    localparam int ASP_TXC_TX_RUN = 7;
    localparam int ASP_TXC_LEN_NINE = 6;
    localparam int ASP_TXC_DRIVE_EN = 5;
    localparam int ASP_TXC_PUSH_PULL = 4;
    localparam int ASP_TXC_LEN_SEVEN = 3;
    localparam int ASP_TXC_NINTH = 2;
    localparam int ASP_TXC_LOAD_DONE = 1;
    localparam int ASP_TXC_IRQ_EN = 0;

    // Reset values of the byte-wide registers.
    localparam logic [7:0] ASP_RST_BYTE = 8'h00;

    // Frame bit counts: data length plus start and stop.
    localparam logic [3:0] ASP_FRAME_NINE = 4'hb;
    localparam logic [3:0] ASP_FRAME_EIGHT = 4'ha;
    localparam logic [3:0] ASP_FRAME_SEVEN = 4'h9;

    // Baud accumulator advances in thirds of a cycle.
    localparam logic [13:0] ASP_BAUD_STEP = 14'h0003;

    // Interrupt vector addresses served by the two request outputs.
    localparam logic [15:0] ASP_VEC_RX = 16'h0033;
    localparam logic [15:0] ASP_VEC_TX = 16'h003b;

endpackage

// [common/asp_baud_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Link between the port core and its shared baud generator.
interface asp_baud_if;
    logic run;            // High while either shifter is busy.
    logic prescale_sel;   // Selects the 32/3 step instead of 8/3.
    logic [7:0] period;   // Programmed baud period value.
    logic tick;           // One-cycle pulse at each bit boundary.
    logic half_tick;      // One-cycle pulse in the middle of each bit.
    modport gen (input run, prescale_sel, period, output tick, half_tick);
    modport user (output run, prescale_sel, period, input tick, half_tick);
endinterface
`default_nettype wire

// [core/asp_baud_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module asp_baud_gen (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Generator side of the baud link.
    asp_baud_if.gen bif
);
    logic [13:0] acc_r;    // Phase accumulator in thirds of a cycle.
    logic [13:0] acc_nxt;  // Next accumulator value.
    logic tick_r;          // Registered bit-boundary pulse.
    logic half_r;          // Registered mid-bit pulse.

    // Period in thirds: (n+1)*8 or (n+1)*32, giving 8/3 or 32/3 cycles.
    wire [8:0] n_plus_one = {1'b0, bif.period} + 9'h001;
    wire [13:0] limit = bif.prescale_sel ? {n_plus_one, 5'h00}
                                         : {2'b00, n_plus_one, 3'h0};
    wire [13:0] half_limit = {1'b0, limit[13:1]};
    wire [13:0] sum = acc_r + asp_pkg::ASP_BAUD_STEP;
    wire wrap = sum >= limit;
    wire cross_half = (acc_r < half_limit) && (sum >= half_limit);

    // Idle forces the counter home so a transfer begun with both directions idle starts in phase.
    always_comb begin
        if (!bif.run) begin
            acc_nxt = 14'h0000;
        end else if (wrap) begin
            acc_nxt = sum - limit;
        end else begin
            acc_nxt = sum;
        end
    end

    // Accumulator and pulse registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= 14'h0000;
            tick_r <= 1'b0;
            half_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            tick_r <= bif.run && wrap;
            half_r <= bif.run && cross_half;
        end
    end

    assign bif.tick = tick_r;
    assign bif.half_tick = half_r;
endmodule
`default_nettype wire

// [core/asp_top.sv]
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Push-pull select chooses transmit pin driver type.
// - Two length bits pick nine, eight or seven.
// - Ninth transmitted bit comes from control bit.
// - Shifter loads; load-done flag sets in the same cycle.
// - Load-done flag clears only by software write.
// - Cleared flag makes transmission restart automatically.
// - Transmit request when enable and flag set.
// - Baud counter resets when both runs idle.
// - Baud period is (n+1) times 8/3 or 32/3.
// - Transmit and receive share one baud generator.
// - Software writes next byte after load-done flag.
// - Reception end copies shifter, ninth bit separately.
// - Seven-bit receptions store zero in bit seven.
// - Reception end clears run, sets done flag.
// - Clearing start detect makes current frame last.
// - Continuous transmit leaves one-cycle gap between frames.
// - Frame end with load-done flag still set ends stream.
// - Pin driven only with drive enable, input direction.
// - Receive request when enable and done flag set.
// - Writing run starts transmission; clearing aborts it.
// - Low stop bit sets sticky stop error flag.
module asp_top (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port direction bits from the port logic, same clock.
    input wire logic tx_pin_dir,
    input wire logic rx_pin_dir,
    // Serial pins.
    input wire logic rx_pin,
    output logic tx_pin_out,
    output logic tx_pin_oe,
    // Interrupt requests.
    output logic rx_irq_req,
    output logic tx_irq_req
);
    // Receive control fields.
    logic baud_prescale_sel_r;  // Baud step select.
    logic start_detect_en_r;    // Start-bit detection enable.
    logic rx_run_r;             // Reception in progress.
    logic stop_error_flag_r;    // Sticky stop-bit error.
    logic spare_flag_r;         // General-purpose bit with no effect.
    logic rx_ninth_bit_r;       // Ninth received bit.
    logic rx_done_flag_r;       // Reception finished.
    logic rx_irq_en_r;          // Receive interrupt enable.
    // Transmit control fields.
    logic tx_run_r;             // Transmission requested or running.
    logic len_nine_sel_r;       // Nine-bit length select.
    logic tx_pin_drive_en_r;    // Transmit pin output enable.
    logic tx_pin_push_pull_sel_r; // Driver type select.
    logic len_seven_sel_r;      // Seven-bit length select.
    logic tx_ninth_bit_r;       // Ninth bit to transmit.
    logic tx_load_done_flag_r;  // Shifter took the data register.
    logic tx_irq_en_r;          // Transmit interrupt enable.
    // Data registers.
    logic [7:0] baud_period_reg_r;
    logic [7:0] tx_data_reg_r;
    logic [7:0] rx_data_reg_r;
    // Transmit shifter state.
    logic tx_active_r;          // Shifter is sending a frame.
    logic [10:0] tx_shifter_r;  // Bit 0 is the bit on the line.
    logic [3:0] tx_cnt_r;       // Bits left in the frame.
    // Receive shifter state.
    logic [10:0] rx_shifter_r;  // Newest sample enters at bit 10.
    logic [3:0] rx_cnt_r;       // Samples left in the frame.
    logic rx_sync1_r;           // First synchroniser stage.
    logic rx_sync2_r;           // Second synchroniser stage.
    logic rx_prev_r;            // Previous synchronised level.
    logic start_det_prev_r;     // Start detect enable one cycle ago.
    // Bus slave state.
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    // Pin and request outputs.
    logic tx_pin_out_r;
    logic tx_pin_oe_r;
    logic rx_irq_req_r;
    logic tx_irq_req_r;

    asp_baud_if bif ();

    // One generator serves both directions.
    asp_baud_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .bif(bif)
    );
    assign bif.run = tx_run_r || rx_run_r;
    assign bif.prescale_sel = baud_prescale_sel_r;
    assign bif.period = baud_period_reg_r;

    // APB decode: one wait state, so read data can come from a flop.
    wire access = psel && penable && !pready_r;
    wire complete = psel && penable && pready_r;
    wire hit_rxc = paddr == asp_pkg::ASP_ADDR_RX_CTL;
    wire hit_txc = paddr == asp_pkg::ASP_ADDR_TX_CTL;
    wire hit_baud = paddr == asp_pkg::ASP_ADDR_BAUD;
    wire hit_txd = paddr == asp_pkg::ASP_ADDR_TX_DATA;
    wire hit_rxd = paddr == asp_pkg::ASP_ADDR_RX_DATA;
    wire hit_any = hit_rxc || hit_txc || hit_baud || hit_txd || hit_rxd;
    wire wr_ok = complete && pwrite && pstrb[0];
    wire wr_rxc = wr_ok && hit_rxc;
    wire wr_txc = wr_ok && hit_txc;
    wire wr_baud = wr_ok && hit_baud;
    wire wr_txd = wr_ok && hit_txd;
    wire wr_rxd = wr_ok && hit_rxd;
    wire [7:0] wb = pwdata[7:0];

    // Control registers as software sees them.
    wire [7:0] rx_ctl_view = {baud_prescale_sel_r, start_detect_en_r,
        rx_run_r, stop_error_flag_r, spare_flag_r, rx_ninth_bit_r,
        rx_done_flag_r, rx_irq_en_r};
    wire [7:0] tx_ctl_view = {tx_run_r, len_nine_sel_r, tx_pin_drive_en_r,
        tx_pin_push_pull_sel_r, len_seven_sel_r, tx_ninth_bit_r,
        tx_load_done_flag_r, tx_irq_en_r};
    wire [7:0] rd_byte = hit_rxc ? rx_ctl_view :
                         hit_txc ? tx_ctl_view :
                         hit_baud ? baud_period_reg_r :
                         hit_txd ? tx_data_reg_r :
                         hit_rxd ? rx_data_reg_r : asp_pkg::ASP_RST_BYTE;

    // Length decode; the forbidden combination falls back to eight.
    wire len_nine = len_nine_sel_r && !len_seven_sel_r;
    wire len_seven = len_seven_sel_r && !len_nine_sel_r;
    wire [3:0] frame_bits = len_nine ? asp_pkg::ASP_FRAME_NINE :
                            len_seven ? asp_pkg::ASP_FRAME_SEVEN :
                            asp_pkg::ASP_FRAME_EIGHT;

    // Transmit frame image, start bit at bit 0, stop above the data.
    wire [10:0] tx_frame = len_nine ?
                           {1'b1, tx_ninth_bit_r, tx_data_reg_r, 1'b0} :
                           len_seven ?
                           {3'b111, tx_data_reg_r[6:0], 1'b0} :
                           {2'b11, tx_data_reg_r, 1'b0};

    // Transmit sequencing.
    wire tx_load = tx_run_r && !tx_active_r;
    wire tx_end = tx_active_r && bif.tick && (tx_cnt_r == 4'h1);
    // A cleared flag at frame end means software refilled the data.
    wire tx_restart = !tx_load_done_flag_r;

    // Receive front end: falling edge or enable while the line is low.
    wire rx_fall = rx_prev_r && !rx_sync2_r;
    wire rx_en_low = !start_det_prev_r && !rx_sync2_r;
    wire rx_start = start_detect_en_r && !rx_run_r &&
                    (rx_fall || rx_en_low);
    wire rx_sample = rx_run_r && bif.half_tick;
    wire rx_end = rx_sample && (rx_cnt_r == 4'h1);
    wire rx_abort = wr_rxc && rx_run_r && !wb[asp_pkg::ASP_RXC_RX_RUN];
    wire rx_finish = rx_end || rx_abort;
    // Final image includes the stop sample taken this cycle.
    wire [10:0] rx_final = rx_end ? {rx_sync2_r, rx_shifter_r[10:1]}
                                  : rx_shifter_r;
    wire [7:0] rx_byte = len_nine ? rx_final[8:1] :
                         len_seven ? {1'b0, rx_final[9:3]} :
                         rx_final[9:2];

    // Transmit pin level and drive; open drain only pulls low.
    wire tx_level = tx_active_r ? tx_shifter_r[0] : 1'b1;
    wire tx_drive = tx_pin_drive_en_r && !tx_pin_dir;
    wire tx_oe_nxt = tx_drive &&
        (tx_pin_push_pull_sel_r || !tx_level);
    wire tx_out_nxt = tx_pin_push_pull_sel_r ? tx_level : 1'b0;

    // Bus slave answer; pready stands for exactly one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= access;
            pslverr_r <= access && !hit_any;
            if (access) begin
                prdata_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Plain configuration and data registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_period_reg_r <= asp_pkg::ASP_RST_BYTE;
            tx_data_reg_r <= asp_pkg::ASP_RST_BYTE;
            baud_prescale_sel_r <= 1'b0;
            start_detect_en_r <= 1'b0;
            spare_flag_r <= 1'b0;
            rx_irq_en_r <= 1'b0;
            len_nine_sel_r <= 1'b0;
            tx_pin_drive_en_r <= 1'b0;
            tx_pin_push_pull_sel_r <= 1'b0;
            len_seven_sel_r <= 1'b0;
            tx_ninth_bit_r <= 1'b0;
            tx_irq_en_r <= 1'b0;
        end else begin
            if (wr_baud) begin
                baud_period_reg_r <= wb;
            end
            if (wr_txd) begin
                tx_data_reg_r <= wb;
            end
            if (wr_rxc) begin
                baud_prescale_sel_r <= wb[asp_pkg::ASP_RXC_PRESCALE];
                start_detect_en_r <= wb[asp_pkg::ASP_RXC_START_DET];
                spare_flag_r <= wb[asp_pkg::ASP_RXC_SPARE];
                rx_irq_en_r <= wb[asp_pkg::ASP_RXC_IRQ_EN];
            end
            if (wr_txc) begin
                len_nine_sel_r <= wb[asp_pkg::ASP_TXC_LEN_NINE];
                tx_pin_drive_en_r <= wb[asp_pkg::ASP_TXC_DRIVE_EN];
                tx_pin_push_pull_sel_r <= wb[asp_pkg::ASP_TXC_PUSH_PULL];
                len_seven_sel_r <= wb[asp_pkg::ASP_TXC_LEN_SEVEN];
                tx_ninth_bit_r <= wb[asp_pkg::ASP_TXC_NINTH];
                tx_irq_en_r <= wb[asp_pkg::ASP_TXC_IRQ_EN];
            end
        end
    end

    // Transmit run bit and load flag.
    // A software write in the frame-end cycle wins over the restart,
    // so a control write there sets run from its own written run bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_run_r <= 1'b0;
            tx_load_done_flag_r <= 1'b0;
        end else begin
            if (wr_txc) begin
                tx_run_r <= wb[asp_pkg::ASP_TXC_TX_RUN];
            end else if (tx_end) begin
                tx_run_r <= tx_restart;
            end
            // Hardware set wins over a clearing write.
            if (tx_load) begin
                tx_load_done_flag_r <= 1'b1;
            end else if (wr_txc) begin
                tx_load_done_flag_r <= wb[asp_pkg::ASP_TXC_LOAD_DONE];
            end
        end
    end

    // Transmit shifter; loses the frame at once when run is cleared.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_active_r <= 1'b0;
            tx_shifter_r <= 11'h7ff;
            tx_cnt_r <= 4'h0;
        end else if (!tx_run_r || tx_end) begin
            tx_active_r <= 1'b0;
            tx_shifter_r <= 11'h7ff;
            tx_cnt_r <= 4'h0;
        end else if (tx_load) begin
            tx_active_r <= 1'b1;
            tx_shifter_r <= tx_frame;
            tx_cnt_r <= frame_bits;
        end else if (bif.tick) begin
            tx_shifter_r <= {1'b1, tx_shifter_r[10:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
        end
    end

    // Receive pin synchroniser and edge history.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync1_r <= 1'b1;
            rx_sync2_r <= 1'b1;
            rx_prev_r <= 1'b1;
            start_det_prev_r <= 1'b0;
        end else begin
            rx_sync1_r <= rx_pin;
            rx_sync2_r <= rx_sync1_r;
            rx_prev_r <= rx_sync2_r;
            start_det_prev_r <= start_detect_en_r;
        end
    end

    // Receive shifter: samples mid-bit, start bit included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shifter_r <= 11'h7ff;
            rx_cnt_r <= 4'h0;
        end else if (rx_start) begin
            rx_shifter_r <= 11'h7ff;
            rx_cnt_r <= frame_bits;
        end else if (rx_sample) begin
            rx_shifter_r <= {rx_sync2_r, rx_shifter_r[10:1]};
            rx_cnt_r <= rx_cnt_r - 4'h1;
        end
    end

    // Receive run, result register and flags; hardware set wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_run_r <= 1'b0;
            rx_data_reg_r <= asp_pkg::ASP_RST_BYTE;
            rx_ninth_bit_r <= 1'b0;
            rx_done_flag_r <= 1'b0;
            stop_error_flag_r <= 1'b0;
        end else begin
            // Software may only clear the run bit, which aborts.
            if (rx_start) begin
                rx_run_r <= 1'b1;
            end else if (rx_finish) begin
                rx_run_r <= 1'b0;
            end
            if (rx_finish) begin
                rx_data_reg_r <= rx_byte;
            end else if (wr_rxd) begin
                rx_data_reg_r <= wb;
            end
            if (rx_finish && len_nine) begin
                rx_ninth_bit_r <= rx_final[9];
            end else if (wr_rxc) begin
                rx_ninth_bit_r <= wb[asp_pkg::ASP_RXC_NINTH];
            end
            if (rx_finish) begin
                rx_done_flag_r <= 1'b1;
            end else if (wr_rxc) begin
                rx_done_flag_r <= wb[asp_pkg::ASP_RXC_DONE];
            end
            if (rx_finish && !rx_final[10]) begin
                stop_error_flag_r <= 1'b1;
            end else if (wr_rxc) begin
                stop_error_flag_r <= wb[asp_pkg::ASP_RXC_STOP_ERR];
            end
        end
    end

    // Pin drive and interrupt requests, all registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pin_out_r <= 1'b1;
            tx_pin_oe_r <= 1'b0;
            rx_irq_req_r <= 1'b0;
            tx_irq_req_r <= 1'b0;
        end else begin
            tx_pin_out_r <= tx_out_nxt;
            tx_pin_oe_r <= tx_oe_nxt;
            rx_irq_req_r <= rx_irq_en_r && rx_done_flag_r;
            tx_irq_req_r <= tx_irq_en_r && tx_load_done_flag_r;
        end
    end

    // The receive direction bit is only a software obligation here.
    wire unused_dir = rx_pin_dir;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign tx_pin_out = tx_pin_out_r;
    assign tx_pin_oe = tx_pin_oe_r;
    assign rx_irq_req = rx_irq_req_r;
    assign tx_irq_req = tx_irq_req_r;
endmodule
`default_nettype wire

// [tb/asp_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// Watches the register bus, the pin output enable and the request outputs of the port.
module asp_monitor (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pin control and requests.
    input wire logic tx_pin_dir,
    input wire logic tx_pin_oe,
    input wire logic rx_irq_req,
    input wire logic tx_irq_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Addresses below the first or above the last byte register.
    wire logic unmapped = paddr < asp_pkg::ASP_ADDR_RX_CTL ||
        paddr > asp_pkg::ASP_ADDR_RX_DATA;
    // A completed, strobed write; request enables sit in bit 0.
    wire logic wr_done = psel && penable && pready && pwrite && pstrb[0];
    pready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("bus answer held too long");
    err_decode_a: assert property (psel && penable && !pready |=>
        pslverr == unmapped) else $error("error answer wrong");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    rdata_high_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    dir_block_a: assert property (tx_pin_dir [*2] |-> !tx_pin_oe)
        else $error("pin driven with port direction out");
    tx_irq_off_a: assert property (wr_done && !pwdata[0] &&
        paddr == asp_pkg::ASP_ADDR_TX_CTL |=> ##1 !tx_irq_req)
        else $error("transmit request stays up");
    rx_irq_off_a: assert property (wr_done && !pwdata[0] &&
        paddr == asp_pkg::ASP_ADDR_RX_CTL |=> ##1 !rx_irq_req)
        else $error("receive request stays up");
endmodule
`default_nettype wire

// [tb/asp_remote.sv]
`timescale 1ns/10ps
`default_nettype none
// Remote transceiver: drives the receive line, decodes the transmit line.
module asp_remote #(
    parameter int BIT = 8  // Cycles per bit, as a baud value of 2 gives.
) (
    // Clock and line ends.
    input wire logic pclk,
    input wire logic tx_wire,
    output logic rx_pin
);
    // The line rests high between frames.
    initial rx_pin = 1'b1;
    // Start bit, data least significant first, then the given stop level.
    task automatic send(input int n, input logic [8:0] d, input logic stp);
        for (int i = -1; i <= n; i++) begin
            rx_pin <= i < 0 ? 1'b0 : i == n ? stp : d[i];
            repeat (BIT) @(posedge pclk);
        end
        rx_pin <= 1'b1;
    endtask
    // Samples mid-bit from the start edge; the stop bit lands at index n.
    task automatic recv(input int n, output logic [9:0] d);
        d = 10'h000;
        @(negedge tx_wire);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i <= n; i++) begin
            repeat (BIT) @(posedge pclk);
            d[i] = tx_wire;
        end
    endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    // Stimulus, idle at time zero.
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, tx_pin_dir = 1'b1, rx_pin_dir = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h1;
    // Outputs, line ends and scratch.
    logic [31:0] prdata, q;
    logic pready, pslverr, tx_pin_out, tx_pin_oe, rx_irq_req, tx_irq_req, e;
    wire logic rx_pin, tx_wire;
    logic [9:0] got;
    int miscompares = 0, n_checks = 0;
    // A pull-up holds the line high wherever nobody drives it.
    assign tx_wire = tx_pin_oe ? tx_pin_out : 1'b1;
    asp_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .tx_pin_dir, .rx_pin_dir, .rx_pin,
        .tx_pin_out, .tx_pin_oe, .rx_irq_req, .tx_irq_req);
    asp_remote i_rem (.pclk, .tx_wire, .rx_pin);
    // One bus transfer; holds the request until pready is seen high.
    task automatic apb(input logic wr, input logic [31:0] a,
        input logic [7:0] d, output logic [31:0] rq, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A transfer that never completes counts as a mismatch.
        if (pready !== 1'b1) begin
            miscompares++;
        end
        rq = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Compares and counts; a mismatch is reported at once.
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Reset values, masked write, read-back and an unmapped address.
    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, asp_pkg::ASP_ADDR_RX_CTL + 32'(4 * i), 8'h00, q, e);
            chk("reset value", q, {24'h00_0000, asp_pkg::ASP_RST_BYTE});
        end
        pstrb <= 4'h0;
        apb(1'b1, asp_pkg::ASP_ADDR_BAUD, 8'h5a, q, e);
        pstrb <= 4'h1;
        apb(1'b0, asp_pkg::ASP_ADDR_BAUD, 8'h00, q, e);
        chk("masked write", q, 32'h0000_0000);
        apb(1'b1, asp_pkg::ASP_ADDR_BAUD, 8'h02, q, e);
        apb(1'b0, asp_pkg::ASP_ADDR_BAUD, 8'h00, q, e);
        chk("baud", q, 32'h0000_0002);
        apb(1'b0, asp_pkg::ASP_ADDR_RX_DATA + 32'h0000_0004, 8'h00, q, e);
        chk("unmapped err", {31'h0000_0000, e}, 32'h0000_0001);
        chk("unmapped data", q, 32'h0000_0000);
        tx_pin_dir <= 1'b0;
    endtask
    // Frames out: nine-bit open drain, eight and seven bits push-pull.
    task automatic t_tx();
        logic [7:0] ctl[3] = '{8'he5, 8'hb1, 8'hb9};
        logic [7:0] dat[3] = '{8'h96, 8'h3c, 8'hc3};
        logic [9:0] want[3] = '{10'h396, 10'h13c, 10'h0c3};
        int len[3] = '{9, 8, 7};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, asp_pkg::ASP_ADDR_TX_DATA, dat[i], q, e);
            fork
                i_rem.recv(len[i], got);
                apb(1'b1, asp_pkg::ASP_ADDR_TX_CTL, ctl[i], q, e);
            join
            chk("frame out", 32'(got), 32'(want[i]));
            repeat (8) @(posedge pclk);
            apb(1'b0, asp_pkg::ASP_ADDR_TX_CTL, 8'h00, q, e);
            chk("tx status", q, 32'(ctl[i] & 8'h7f | 8'h02));
            chk("tx request", 32'(tx_irq_req), 32'h0000_0001);
            apb(1'b1, asp_pkg::ASP_ADDR_TX_CTL, 8'h00, q, e);
        end
    endtask
    // Frames in at each length; the last carries a low stop bit.
    task automatic t_rx();
        logic [7:0] len[3] = '{8'h00, 8'h08, 8'h40};
        logic [8:0] dat[3] = '{9'h0a6, 9'h07f, 9'h15a};
        logic [7:0] rd[3] = '{8'ha6, 8'h7f, 8'h5a};
        logic [7:0] st[3] = '{8'h43, 8'h43, 8'h57};
        int n[3] = '{8, 7, 9};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, asp_pkg::ASP_ADDR_TX_CTL, len[i], q, e);
            apb(1'b1, asp_pkg::ASP_ADDR_RX_CTL, 8'h41, q, e);
            i_rem.send(n[i], dat[i], 1'(i < 2));
            repeat (16) @(posedge pclk);
            apb(1'b0, asp_pkg::ASP_ADDR_RX_DATA, 8'h00, q, e);
            chk("rx data", q, {24'h00_0000, rd[i]});
            apb(1'b0, asp_pkg::ASP_ADDR_RX_CTL, 8'h00, q, e);
            chk("rx status", q, {24'h00_0000, st[i]});
            chk("rx request", 32'(rx_irq_req), 32'h0000_0001);
        end
        apb(1'b1, asp_pkg::ASP_ADDR_RX_CTL, 8'h00, q, e);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Clock at 100 MHz.
    initial forever #5 pclk = ~pclk;
    // The tests need under a thousand cycles, so this only cuts hangs.
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end
    // Reset for six cycles, then the scenarios in turn.
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        wrap_up();
    end
endmodule
bind asp_top asp_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_pin_dir,
    .tx_pin_oe, .rx_irq_req, .tx_irq_req);
`default_nettype wire
